// File: logic/uvc_map.svh
// Register offsets, field positions, reset values and counts for the block.
`ifndef UVC_MAP_SVH
`define UVC_MAP_SVH
`define UVC_ADDR_W        4
`define UVC_OFF_VECTOR    4'h0
`define UVC_OFF_INPORT    4'h1
`define UVC_OFF_RTS_SET   4'h2
`define UVC_OFF_RTS_CLR   4'h3
`define UVC_OFF_DIV_HI    4'h4
`define UVC_OFF_DIV_LO    4'h5
`define UVC_OFF_CLK_SEL   4'h6
`define UVC_OFF_AUX       4'h7
`define UVC_OFF_STATUS    4'h8
`define UVC_OFF_MASK      4'h9
`define UVC_OFF_PCHG      4'hA
`define UVC_VECTOR_RST    8'h0F
`define UVC_DIV_RST       16'h0000
`define UVC_PRESCALE      5'h1F
`define UVC_TIN_DIV       4'hF
`define UVC_BIT_CMD       0
`define UVC_BIT_CTS       0
`define UVC_BIT_PCHG_COS  4
`define UVC_BIT_ST_COS    7
`define UVC_BIT_ST_DB     2
`define UVC_BIT_ST_FULL   1
`define UVC_BIT_ST_TXRDY  0
`define UVC_BIT_SEL_TIN   0
`define UVC_BIT_SEL_SYNC  1
`define UVC_BIT_AUX_IEC   0
`define UVC_DMA_CH_FIRST  2'h2
`define UVC_DMA_CH_SECOND 2'h3
`endif

// File: logic/uvc_pkg.sv
// Types shared by the serial channel vector, port and clock logic.
package uvc_pkg;
	// Register access from software.
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} uvc_req_type;
	// Events from the transmit and receive engines.
	typedef struct packed {
		logic tx_ready;
		logic rx_ready_full;
		logic delta_break;
		logic fifo_full_flag;
	} uvc_engine_type;
	// Automatic request-to-send control.
	typedef enum logic [1:0] {
		UVC_RTS_MANUAL,
		UVC_RTS_BY_RX,
		UVC_RTS_BY_TX,
		UVC_RTS_SPARE
	} uvc_rts_mode_type;
	// Transmit shifter state.
	typedef enum logic [1:0] {
		UVC_TX_IDLE,
		UVC_TX_SHIFT,
		UVC_TX_DONE
	} uvc_tx_state_type;
endpackage

// File: logic/uvc_top.sv
// Vector, port, request-to-send, interrupt and baud clock logic of a channel.
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "uvc_map.svh"

module uvc_top #(
	parameter bit SECOND_CHANNEL = 1'b0
) (
	// Clock and reset.
	input  wire logic                  clock,
	input  wire logic                  rst_n,
	// Register port.
	input  wire uvc_pkg::uvc_req_type  req,
	output logic [7:0]                 rdata,
	// Engine events and transmit data.
	input  wire uvc_pkg::uvc_engine_type eng,
	input  wire logic                  tx_enable,
	input  wire logic                  loopback,
	input  wire logic                  tx_load,
	input  wire logic [7:0]            tx_byte,
	input  wire logic                  rx_sample_en,
	// Serial pins.
	input  wire logic                  cts_n,
	input  wire logic                  rxd,
	input  wire logic                  timer_input_clock,
	output logic                       txd,
	output logic                       rts_n,
	// Interrupt controller side.
	input  wire logic                  int_ack,
	input  wire logic                  autovector_sel,
	output logic                       irq_n,
	output logic                       vector_drive,
	output logic [7:0]                 vector_number,
	output logic                       dma_req,
	output logic [1:0]                 dma_channel,
	// Clock and timing results.
	output logic                       baud_tick,
	output logic                       serial_clock,
	output logic                       tx_busy,
	output logic [7:0]                 rx_data,
	output logic                       timer_capture_ok
);
	import uvc_pkg::*;

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	logic [7:0]        vector_reg_q;
	logic [7:0]        divider_high_q;
	logic [7:0]        divider_low_q;
	logic [1:0]        clock_select_q;
	logic [0:0]        aux_iec_q;
	uvc_rts_mode_type  rts_mode_q;
	logic [7:0]        int_mask_q;
	logic              rts_on_q;
	logic              cts_prev_q;
	logic              pchg_cos_q;
	logic              st_cos_q;
	logic              tx_done_pulse;
	logic [7:0]        int_status;
	logic              wr_vec;
	logic              rd_pchg;

	assign wr_vec  = req.wr && req.addr == `UVC_OFF_VECTOR;
	assign rd_pchg = req.rd && req.addr == `UVC_OFF_PCHG;

	// Vector register; all eight bits are the vector number.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			vector_reg_q <= `UVC_VECTOR_RST;
		end else if (wr_vec) begin
			vector_reg_q <= req.wdata;
		end
	end

	// Divider bytes, clock select, auxiliary control and mask.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			divider_high_q <= 8'(`UVC_DIV_RST >> 8);
			divider_low_q  <= 8'(`UVC_DIV_RST);
			clock_select_q <= 2'h0;
			aux_iec_q      <= 1'h0;
			rts_mode_q     <= UVC_RTS_MANUAL;
			int_mask_q     <= 8'h00;
		end else if (req.wr) begin
			case (req.addr)
				`UVC_OFF_DIV_HI:  divider_high_q <= req.wdata;
				`UVC_OFF_DIV_LO:  divider_low_q  <= req.wdata;
				`UVC_OFF_CLK_SEL: clock_select_q <= req.wdata[1:0];
				`UVC_OFF_AUX: begin
					aux_iec_q  <= req.wdata[`UVC_BIT_AUX_IEC];
					rts_mode_q <= uvc_rts_mode_type'(req.wdata[2:1]);
				end
				`UVC_OFF_MASK:    int_mask_q <= req.wdata;
				default: ;
			endcase
		end
	end

	// Status word as software sees it; true status whatever the mask.
	always_comb begin
		int_status = 8'h00;
		int_status[`UVC_BIT_ST_COS]   = st_cos_q;
		int_status[`UVC_BIT_ST_DB]    = eng.delta_break;
		int_status[`UVC_BIT_ST_FULL]  = eng.rx_ready_full;
		int_status[`UVC_BIT_ST_TXRDY] = eng.tx_ready;
	end

	// Read data stands in the cycle after the strobe. Divider bytes
	// are write-only and read as zero, like any unmapped offset.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 8'h00;
		end else if (req.rd) begin
			case (req.addr)
				`UVC_OFF_VECTOR:  rdata <= vector_reg_q;
				`UVC_OFF_INPORT:  rdata <= {7'h00, cts_n};
				`UVC_OFF_CLK_SEL: rdata <= {6'h00, clock_select_q};
				`UVC_OFF_AUX:     rdata <= {5'h00, rts_mode_q, aux_iec_q};
				`UVC_OFF_STATUS:  rdata <= int_status;
				`UVC_OFF_MASK:    rdata <= int_mask_q;
				`UVC_OFF_PCHG: begin
					rdata <= {3'h0, pchg_cos_q, 3'h0, cts_n};
				end
				default:          rdata <= 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end

	// ------------------------------------------------------------
	// Clear-to-send change detection
	// ------------------------------------------------------------
	// The pin is taken as synchronous, so one stage finds the edges.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cts_prev_q <= 1'b1;
		end else begin
			cts_prev_q <= cts_n;
		end
	end

	// Reading the change register clears both change flags; a change
	// seen in the same cycle wins, so no edge is lost.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pchg_cos_q <= 1'b0;
			st_cos_q   <= 1'b0;
		end else if (cts_prev_q != cts_n) begin
			pchg_cos_q <= 1'b1;
			if (aux_iec_q[0]) begin
				st_cos_q <= 1'b1;
			end else if (rd_pchg) begin
				st_cos_q <= 1'b0;
			end
		end else if (rd_pchg) begin
			pchg_cos_q <= 1'b0;
			st_cos_q   <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Request-to-send
	// ------------------------------------------------------------
	// Command writes win over automatic control in the same cycle,
	// because software intent is the more recent decision.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rts_on_q <= 1'b0;
		end else if (req.wr && req.addr == `UVC_OFF_RTS_SET
				&& req.wdata[`UVC_BIT_CMD]) begin
			rts_on_q <= 1'b1;
		end else if (req.wr && req.addr == `UVC_OFF_RTS_CLR
				&& req.wdata[`UVC_BIT_CMD]) begin
			rts_on_q <= 1'b0;
		end else begin
			case (rts_mode_q)
				UVC_RTS_BY_RX: rts_on_q <= !eng.fifo_full_flag;
				UVC_RTS_BY_TX: begin
					if (tx_done_pulse && !tx_enable) begin
						rts_on_q <= 1'b0;
					end
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rts_n <= 1'b1;
		end else begin
			rts_n <= !rts_on_q;
		end
	end

	// ------------------------------------------------------------
	// Interrupt request, vector and DMA routing
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			irq_n         <= 1'b1;
			vector_drive  <= 1'b0;
			vector_number <= 8'h00;
			dma_req       <= 1'b0;
			dma_channel   <= `UVC_DMA_CH_FIRST;
		end else begin
			irq_n <= ~|(int_status & int_mask_q);
			// Drive the vector only when no autovector is chosen.
			vector_drive  <= int_ack && !autovector_sel;
			vector_number <= (int_ack && !autovector_sel) ?
				vector_reg_q : 8'h00;
			dma_req <= int_mask_q[`UVC_BIT_ST_FULL]
				&& eng.fifo_full_flag;
			dma_channel <= SECOND_CHANNEL ?
				`UVC_DMA_CH_SECOND : `UVC_DMA_CH_FIRST;
		end
	end

	// ------------------------------------------------------------
	// Baud clock generation
	// ------------------------------------------------------------
	logic [4:0]  prescale_q;
	logic [15:0] div_count_q;
	logic [15:0] div_load_q;
	logic [3:0]  tin_count_q;
	logic        tin_prev_q;
	logic        tin_rise;
	logic        bus_tick;
	logic        tin_tick;
	logic        src_tick;
	logic        use_tin;

	assign use_tin  = clock_select_q[`UVC_BIT_SEL_TIN];
	assign tin_rise = timer_input_clock && !tin_prev_q;

	// Fixed divide by 32 of the bus clock.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			prescale_q <= 5'h00;
		end else if (prescale_q == `UVC_PRESCALE) begin
			prescale_q <= 5'h00;
		end else begin
			prescale_q <= prescale_q + 5'h01;
		end
	end

	// The divisor is taken only at reload so a write never shortens the baud
	// period in progress; a value below 2 is the software's fault.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			div_count_q <= 16'h0001;
			div_load_q  <= `UVC_DIV_RST;
			bus_tick    <= 1'b0;
		end else begin
			bus_tick <= 1'b0;
			if (prescale_q == `UVC_PRESCALE) begin
				if (div_count_q >= div_load_q) begin
					bus_tick    <= 1'b1;
					div_count_q <= 16'h0001;
					div_load_q  <= {divider_high_q, divider_low_q};
				end else begin
					div_count_q <= div_count_q + 16'h0001;
				end
			end
		end
	end

	// Timer input edges, undivided for synchronous mode or by 16.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tin_prev_q  <= 1'b0;
			tin_count_q <= 4'h0;
			tin_tick    <= 1'b0;
		end else begin
			tin_prev_q <= timer_input_clock;
			tin_tick   <= 1'b0;
			if (tin_rise) begin
				if (clock_select_q[`UVC_BIT_SEL_SYNC]) begin
					tin_tick <= 1'b1;
				end else if (tin_count_q == `UVC_TIN_DIV) begin
					tin_tick    <= 1'b1;
					tin_count_q <= 4'h0;
				end else begin
					tin_count_q <= tin_count_q + 4'h1;
				end
			end
		end
	end

	assign src_tick = use_tin ? tin_tick : bus_tick;

	// Serial clock toggles on each tick; rise and fall are enables.
	logic sclk_rise;
	logic sclk_fall;
	assign sclk_rise = src_tick && !serial_clock;
	assign sclk_fall = src_tick && serial_clock;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			serial_clock     <= 1'b0;
			baud_tick        <= 1'b0;
			timer_capture_ok <= 1'b1;
		end else begin
			baud_tick <= src_tick;
			if (src_tick) begin
				serial_clock <= !serial_clock;
			end
			timer_capture_ok <= !use_tin;
		end
	end

	// ------------------------------------------------------------
	// Bit shifting
	// ------------------------------------------------------------
	uvc_tx_state_type tx_state_q;
	logic [7:0]       tx_shift_q;
	logic [2:0]       tx_bits_q;

	assign tx_done_pulse = tx_state_q == UVC_TX_DONE;

	// A load while busy is ignored; the engine waits for tx_busy low.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tx_state_q <= UVC_TX_IDLE;
			tx_shift_q <= 8'hFF;
			tx_bits_q  <= 3'h0;
			txd        <= 1'b1;
		end else begin
			case (tx_state_q)
				UVC_TX_IDLE: begin
					txd <= 1'b1;
					if (tx_load && tx_enable && !loopback) begin
						tx_shift_q <= tx_byte;
						tx_bits_q  <= 3'h0;
						tx_state_q <= UVC_TX_SHIFT;
					end
				end
				UVC_TX_SHIFT: begin
					if (loopback) begin
						txd <= 1'b1;
					end
					if (sclk_fall) begin
						if (!loopback) begin
							txd <= tx_shift_q[0];
						end
						tx_shift_q <= {1'b1, tx_shift_q[7:1]};
						tx_bits_q  <= tx_bits_q + 3'h1;
						if (tx_bits_q == 3'h7) begin
							tx_state_q <= UVC_TX_DONE;
						end
					end
				end
				UVC_TX_DONE: begin
					if (sclk_fall) begin
						txd        <= 1'b1;
						tx_state_q <= UVC_TX_IDLE;
					end
				end
				default: tx_state_q <= UVC_TX_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tx_busy <= 1'b0;
		end else begin
			tx_busy <= tx_state_q != UVC_TX_IDLE;
		end
	end

	// New bits enter at the top so the first lands in bit 0 after 8.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rx_data <= 8'h00;
		end else if (sclk_rise && rx_sample_en) begin
			rx_data <= {rxd, rx_data[7:1]};
		end
	end
endmodule
`default_nettype wire

// File: verification/uvc_top_asserts.sv
// Concurrent checks on the ports of the channel vector and clock block.
`timescale 1ns/100ps
`default_nettype none
module uvc_top_asserts #(
	parameter bit SECOND_CHANNEL = 1'b0
) (
	// Clock and reset.
	input wire logic                    clock,
	input wire logic                    rst_n,
	// Register port.
	input wire uvc_pkg::uvc_req_type    req,
	input wire logic [7:0]              rdata,
	// Pins and engine events.
	input wire uvc_pkg::uvc_engine_type eng,
	input wire logic                    cts_n,
	input wire logic                    txd,
	input wire logic                    rts_n,
	// Interrupt side.
	input wire logic                    int_ack,
	input wire logic                    autovector_sel,
	input wire logic                    vector_drive,
	input wire logic [7:0]              vector_number,
	input wire logic                    dma_req,
	input wire logic [1:0]              dma_channel,
	// Timing results.
	input wire logic                    tx_busy,
	input wire logic                    serial_clock,
	input wire logic                    baud_tick
);
	import uvc_pkg::*;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	// A command write with bit 0 set; other bits are don't-care.
	sequence s_cmd(logic [3:0] a);
		req.wr && req.addr == a && req.wdata[0];
	endsequence
	a_inport_read: assert property ($past(req.rd && req.addr == 4'h1) |->
		rdata == {7'h00, $past(cts_n)}) else $error("port read wrong");
	a_rts_assert: assert property (s_cmd(4'h2) |-> ##[1:2] !rts_n)
		else $error("rts not asserted");
	a_rts_negate: assert property (s_cmd(4'h3) |-> ##[1:2] rts_n)
		else $error("rts not negated");
	a_vector_drive: assert property (
		vector_drive == $past(int_ack && !autovector_sel))
		else $error("vector drive wrong");
	a_vector_quiet: assert property (!vector_drive |-> vector_number == 8'h00)
		else $error("vector bus not quiet");
	a_dma_channel: assert property (
		dma_channel == (SECOND_CHANNEL ? 2'h3 : 2'h2))
		else $error("dma channel wrong");
	a_dma_full: assert property (dma_req |-> $past(eng.fifo_full_flag))
		else $error("dma without full fifo");
	a_txd_idle: assert property (!tx_busy && !$past(tx_busy) |-> txd)
		else $error("txd not at mark");
	a_tx_fall: assert property ($changed(txd) |-> !serial_clock)
		else $error("txd moved off falling edge");
	a_tick_gap: assert property (baud_tick |=> !baud_tick [*8])
		else $error("baud ticks too close");
endmodule
`default_nettype wire

// File: verification/uvc_remote_model.sv
// Far-end serial device model driving the receive data and CTS pins.
`timescale 1ns/100ps
`default_nettype none
module uvc_remote_model (
	// Clock and reset.
	input  wire logic       clock,
	input  wire logic       rst_n,
	// Serial pins.
	input  wire logic       serial_clock,
	output logic            rxd,
	output logic            cts_n,
	// Test control.
	input  wire logic       busy,
	input  wire logic       go,
	input  wire logic [7:0] byte_in
);
	logic       sclk_q;
	logic [8:0] shift_q;
	// A busy far end keeps its ready line negated.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cts_n <= 1'b1;
		end else begin
			cts_n <= busy;
		end
	end
	// Bits change just after a falling serial clock, so they are steady
	// at the rising edge; ones shift in behind, leaving the line at mark.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sclk_q  <= 1'b0;
			shift_q <= 9'h1FF;
			rxd     <= 1'b1;
		end else begin
			sclk_q <= serial_clock;
			if (go) begin
				shift_q <= {1'b1, byte_in};
			end else if (sclk_q && !serial_clock) begin
				rxd     <= shift_q[0];
				shift_q <= {1'b1, shift_q[8:1]};
			end
		end
	end
endmodule
`default_nettype wire

// File: verification/uvc_top_tb_top.sv
// Self-checking bench for the channel vector, port and clock block.
`timescale 1ns/100ps
`default_nettype none
module uvc_top_tb_top;
	import uvc_pkg::*;
	logic           clock = 1'b0;
	logic           rst_n, tx_enable, loopback, tx_load, rx_sample_en;
	logic           tin_run, timer_capture_ok;
	logic [3:0]     tin_div;
	logic           cts_n, rxd, txd, rts_n, int_ack, autovector_sel, irq_n;
	logic           vector_drive, dma_req, baud_tick, serial_clock, tx_busy;
	logic           busy, go;
	logic [1:0]     dma_channel;
	logic [7:0]     rdata, tx_byte, vector_number, rx_data, byte_in, d;
	logic [15:0]    n;
	uvc_req_type    req;
	uvc_engine_type eng;
	int             fail_count, cmp_count;
	uvc_top dut (
		.clock, .rst_n, .req, .rdata, .eng, .tx_enable, .loopback,
		.tx_load, .tx_byte, .rx_sample_en, .cts_n, .rxd,
		.timer_input_clock(tin_div[3]), .txd, .rts_n, .int_ack, .autovector_sel,
		.irq_n, .vector_drive, .vector_number, .dma_req, .dma_channel,
		.baud_tick, .serial_clock, .tx_busy, .rx_data, .timer_capture_ok
	);
	uvc_remote_model peer (
		.clock, .rst_n, .serial_clock, .rxd, .cts_n, .busy, .go, .byte_in
	);
	// 250 MHz clock.
	always #2 clock = ~clock;
	// Timer input pin: a square wave of 16 clocks while enabled.
	always @(posedge clock) tin_div <= tin_run ? tin_div + 4'h1 : 4'h0;
	// ----------------------------------------
	// Access and comparison tasks
	// ----------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, got, exp);
		end
	endtask
	// Waits k edges and lets their updates land before sampling.
	task automatic cyc(input int k);
		repeat (k) @(posedge clock);
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clock);
		req.addr <= a;
		req.wdata <= v;
		req.wr <= 1'b1;
		@(posedge clock);
		req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge clock);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge clock);
		req.rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	task automatic cmd(input logic [3:0] a, input logic [7:0] v,
		input logic e);
		wr(a, v);
		cyc(2);
		chk(16'(rts_n), 16'(e));
	endtask
	// Cycles from one baud tick to the next; both waits are bounded.
	task automatic tick_gap;
		n = 16'h0001;
		#1;
		for (int i = 0; i < 9000 && baud_tick !== 1'b1; i++) cyc(1);
		cyc(1);
		for (int i = 0; i < 9000 && baud_tick !== 1'b1; i++) begin
			cyc(1);
			n++;
		end
	endtask
	task automatic give_verdict;
		$display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Whole run needs about 29k cycles; a hang is cut off well beyond.
	initial begin
		repeat (60000) @(posedge clock);
		fail_count++;
		give_verdict;
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{rst_n, tx_enable, loopback, tx_load, rx_sample_en, tin_run} = '0;
		{int_ack, autovector_sel, go, req, eng, tx_byte, byte_in} = '0;
		busy = 1'b1;
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		rd(4'h0);
		chk(16'(d), 16'h000F);
		wr(4'h0, 8'hA5);
		rd(4'h0);
		chk(16'(d), 16'h00A5);
		rd(4'hF);
		chk(16'(d), 16'h0000);
		wr(4'h1, 8'hFF);
		for (int v = 1; v >= 0; v--) begin
			@(posedge clock);
			busy <= v[0];
			cyc(3);
			rd(4'h1);
			chk(16'(d), 16'(v[0]));
		end
		cmd(4'h2, 8'hFE, 1'b1);
		cmd(4'h2, 8'h01, 1'b0);
		cmd(4'h3, 8'hFE, 1'b0);
		cmd(4'h3, 8'h01, 1'b1);
		// Masked and unmasked transmit-ready status.
		@(posedge clock);
		eng.tx_ready <= 1'b1;
		wr(4'h9, 8'h01);
		cyc(3);
		chk(16'(irq_n), 16'h0000);
		wr(4'h9, 8'h00);
		cyc(3);
		chk(16'(irq_n), 16'h0001);
		rd(4'h8);
		chk(16'(d[0]), 16'h0001);
		eng.tx_ready <= 1'b0;
		// A CTS change raises the request until the change flag is read.
		wr(4'h7, 8'h01);
		rd(4'hA);
		wr(4'h9, 8'h80);
		@(posedge clock);
		busy <= 1'b1;
		cyc(6);
		chk(16'(irq_n), 16'h0000);
		rd(4'hA);
		chk(16'(d[4]), 16'h0001);
		cyc(3);
		chk(16'(irq_n), 16'h0001);
		wr(4'h9, 8'h00);
		wr(4'h7, 8'h00);
		@(posedge clock);
		int_ack <= 1'b1;
		cyc(2);
		chk(16'(vector_drive), 16'h0001);
		chk(16'(vector_number), 16'h00A5);
		@(posedge clock);
		autovector_sel <= 1'b1;
		cyc(2);
		chk(16'(vector_drive), 16'h0000);
		int_ack <= 1'b0;
		eng.fifo_full_flag <= 1'b1;
		wr(4'h9, 8'h02);
		cyc(2);
		chk({15'h0000, dma_req}, 16'h0001);
		chk(16'(dma_channel), 16'h0002);
		wr(4'h9, 8'h00);
		cyc(2);
		chk(16'(dma_req), 16'h0000);
		eng.fifo_full_flag <= 1'b0;
		// Receiver-driven flow control follows the FIFO-full level.
		wr(4'h7, 8'h02);
		cyc(3);
		chk(16'(rts_n), 16'h0000);
		eng.fifo_full_flag <= 1'b1;
		cyc(3);
		chk(16'(rts_n), 16'h0001);
		eng.fifo_full_flag <= 1'b0;
		wr(4'h7, 8'h00);
		// Baud rates: prescaler alone, then high and low divider bytes.
		tick_gap;
		chk(n, 16'h0020);
		wr(4'h4, 8'h01);
		wr(4'h5, 8'h00);
		tick_gap;
		tick_gap;
		chk(n, 16'h2000);
		wr(4'h5, 8'h02);
		wr(4'h4, 8'h00);
		tick_gap;
		tick_gap;
		chk(n, 16'h0040);
		// Transmit a character, sampling each bit at the rising edge;
		// the transmitter is disabled the cycle after the load, before the first bit, so rts drops at end.
		wr(4'h7, 8'h04);
		wr(4'h2, 8'h01);
		@(posedge clock);
		tx_enable <= 1'b1;
		tx_byte <= 8'h4B;
		cyc(2);
		chk(16'(txd), 16'h0001);
		@(negedge serial_clock);
		@(posedge clock);
		tx_load <= 1'b1;
		@(posedge clock);
		tx_load <= 1'b0;
		tx_enable <= 1'b0;
		@(posedge serial_clock);
		for (int i = 0; i < 8; i++) begin
			@(posedge serial_clock);
			#1;
			d[i] = txd;
		end
		chk(16'(d), 16'h004B);
		chk(16'(tx_busy), 16'h0001);
		@(posedge serial_clock);
		#1;
		chk(16'(txd), 16'h0001);
		chk(16'(tx_busy), 16'h0000);
		chk(16'(rts_n), 16'h0001);
		// A load in loop-back must leave the line at mark.
		@(posedge clock);
		tx_enable <= 1'b1;
		loopback <= 1'b1;
		tx_byte <= 8'h00;
		tx_load <= 1'b1;
		@(posedge clock);
		tx_load <= 1'b0;
		repeat (4) @(posedge serial_clock);
		#1;
		chk(16'(txd), 16'h0001);
		// Receive a character sent lsb first by the far end.
		@(posedge clock);
		byte_in <= 8'hC6;
		go <= 1'b1;
		@(posedge clock);
		go <= 1'b0;
		@(negedge serial_clock);
		rx_sample_en <= 1'b1;
		repeat (8) @(posedge serial_clock);
		@(posedge clock);
		rx_sample_en <= 1'b0;
		cyc(2);
		chk(16'(rx_data), 16'h00C6);
		// Timer input as clock: each rising edge, then every sixteenth.
		chk(16'(timer_capture_ok), 16'h0001);
		wr(4'h6, 8'h03);
		@(posedge clock);
		tin_run <= 1'b1;
		tick_gap;
		tick_gap;
		chk(n, 16'h0010);
		chk(16'(timer_capture_ok), 16'h0000);
		wr(4'h6, 8'h01);
		tick_gap;
		tick_gap;
		chk(n, 16'h0100);
		give_verdict;
	end
endmodule
bind uvc_top uvc_top_asserts #(.SECOND_CHANNEL(SECOND_CHANNEL)) u_chk (
	.clock, .rst_n, .req, .rdata, .eng, .cts_n, .txd, .rts_n, .int_ack,
	.autovector_sel, .vector_drive, .vector_number, .dma_req, .dma_channel,
	.tx_busy, .serial_clock, .baud_tick
);
`default_nettype wire
